/* verilog/irq_logic_params.svh */
`ifndef IRQ_LOGIC_PARAMS_SVH
`define IRQ_LOGIC_PARAMS_SVH
// Register offsets
`define OFS_IRQ_CONTROL 8'h0b
`define OFS_PERIPH_IRQ_FLAGS 8'h0c
`define OFS_TIMER1_COUNT_LOW 8'h0e
`define OFS_TIMER1_COUNT_HIGH 8'h0f
`define OFS_TIMER1_CONTROL 8'h10
`define OFS_PERIPH_IRQ_ENABLES 8'h8c
`define OFS_TIMER0_COUNT 8'h01
`define OFS_OPTION 8'h81
`define OFS_COMPARE_MODE 8'h17
`define OFS_IRQ_STATUS 8'h90
`define OFS_IRQ_ENABLE 8'h91
`define OFS_IRQ_CLEAR 8'h92
// Register bit fields
`define BIT_GLOBAL_EN 7
`define BIT_GROUP_EN 6
`define BIT_TIMER0_EN 5
`define BIT_PIN_EN 4
`define BIT_PORT_EN 3
`define BIT_TIMER0_FLAG 2
`define BIT_PIN_FLAG 1
`define BIT_PORT_FLAG 0
`define BIT_EDGE_SEL 6
`define BIT_T1_ON 0
`define BIT_T1_OVF 0
`define PERIPH_MASK 8'h4f
// Values
`define IRQ_VECTOR 13'h0004
`define COMPARE_SPECIAL_EVENT 4'hb
`define RESET_IRQ_CONTROL 8'h00
`define RESET_OPTION 8'hff
`define RESET_BYTE 8'h00
`define LATENCY_HOLD 2'h2
`endif

/* verilog/irq_logic_pkg.sv */
package irq_logic_pkg;
  typedef enum logic [1:0] {run_st, hold_st, vector_st} seq_e;
  typedef logic [7:0] byte_t;
endpackage

/* verilog/mcu_interrupt_logic.sv */
`timescale 1ns/1ps
`include "irq_logic_params.svh"
module mcu_interrupt_logic #(
  parameter int NUM_SOURCES = 8
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Instruction cycle enable
  input wire logic cycle_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Pins
  input wire logic ext_irq_pin,
  input wire logic [3:0] port_b_a,
  // Peripheral events
  input wire logic [7:0] periph_events,
  input wire logic compare_match,
  // Core handshake
  input wire logic core_sleeping,
  input wire logic return_from_irq_instr,
  input wire logic [12:0] return_pc,
  output logic irq_vector_take,
  output logic [12:0] vector_pc,
  output logic [12:0] push_addr,
  output logic push_stack,
  output logic wake,
  output logic adc_start,
  output logic irq
);
  logic [7:0] irq_control, next_irq_control;
  logic [7:0] periph_irq_flags, next_periph_irq_flags;
  logic [7:0] periph_irq_enables, next_periph_irq_enables;
  logic [7:0] timer1_control, next_timer1_control;
  logic [15:0] timer1_count, next_timer1_count;
  logic [7:0] timer0_count, next_timer0_count;
  logic [7:0] option_reg, next_option_reg;
  logic [3:0] compare_mode_select, next_compare_mode_select;
  logic [7:0] irq_enable, next_irq_enable;
  logic [7:0] irq_status, next_irq_status;
  logic pin_q, next_pin_q;
  logic [3:0] port_q, next_port_q;
  irq_logic_pkg::seq_e seq, next_seq;
  logic [1:0] hold_cnt, next_hold_cnt;
  logic [12:0] next_push_addr;
  logic next_push_stack, next_vector_take, next_adc_start;
  logic [7:0] next_reg_rdata;
  logic request, pend_any, pin_edge, port_change, t0_ovf, t1_ovf, special_evt, t1_write;
  logic [NUM_SOURCES-1:0] src_events;

  function automatic logic hit(input logic [7:0] a);
    hit = (reg_addr == a);
  endfunction

  always_comb
  begin
    pin_edge = option_reg[`BIT_EDGE_SEL] ? (ext_irq_pin & ~pin_q) : (~ext_irq_pin & pin_q);
    port_change = |(port_b_a ^ port_q);
    t0_ovf = cycle_en && (timer0_count == 8'hff);
    special_evt = compare_match && (compare_mode_select == `COMPARE_SPECIAL_EVENT);
    t1_ovf = cycle_en && timer1_control[`BIT_T1_ON] && (timer1_count == 16'hffff)
      && !special_evt;
    pend_any = |(irq_control[5:3] & irq_control[2:0])
      | |(periph_irq_enables & periph_irq_flags);
    request = irq_control[`BIT_GLOBAL_EN] && (|(irq_control[5:3] & irq_control[2:0])
      || (irq_control[`BIT_GROUP_EN] && |(periph_irq_enables & periph_irq_flags)));
    src_events = {periph_events[7:1], t1_ovf};
    t1_write = reg_wr && (hit(`OFS_TIMER1_COUNT_LOW) || hit(`OFS_TIMER1_COUNT_HIGH));
  end

  always_comb
  begin
    next_irq_control = irq_control;
    next_periph_irq_flags = periph_irq_flags;
    next_periph_irq_enables = periph_irq_enables;
    next_timer1_control = timer1_control;
    next_timer1_count = timer1_count;
    next_timer0_count = timer0_count;
    next_option_reg = option_reg;
    next_compare_mode_select = compare_mode_select;
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    next_pin_q = ext_irq_pin;
    next_port_q = port_b_a;
    next_adc_start = 1'b0;
    if (cycle_en)
    begin
      next_timer0_count = timer0_count + 8'h01;
      if (timer1_control[`BIT_T1_ON])
      begin
        next_timer1_count = timer1_count + 16'h0001;
      end
    end
    // A coincident software write blocks the clear; the unwritten byte keeps its count
    if (special_evt && !t1_write)
    begin
      next_timer1_count = 16'h0000;
    end
    if (special_evt)
    begin
      next_adc_start = 1'b1;
    end
    // Software writes first; hardware sets override clears
    if (reg_wr)
    begin
      if (hit(`OFS_IRQ_CONTROL))
      begin
        next_irq_control = reg_wdata;
      end
      else if (hit(`OFS_PERIPH_IRQ_FLAGS))
      begin
        next_periph_irq_flags = reg_wdata & `PERIPH_MASK;
      end
      else if (hit(`OFS_PERIPH_IRQ_ENABLES))
      begin
        next_periph_irq_enables = reg_wdata & `PERIPH_MASK;
      end
      else if (hit(`OFS_TIMER1_COUNT_LOW))
      begin
        next_timer1_count[7:0] = reg_wdata;
      end
      else if (hit(`OFS_TIMER1_COUNT_HIGH))
      begin
        next_timer1_count[15:8] = reg_wdata;
      end
      else if (hit(`OFS_TIMER1_CONTROL))
      begin
        next_timer1_control = reg_wdata & 8'h3f;
      end
      else if (hit(`OFS_TIMER0_COUNT))
      begin
        next_timer0_count = reg_wdata;
      end
      else if (hit(`OFS_OPTION))
      begin
        next_option_reg = reg_wdata;
      end
      else if (hit(`OFS_COMPARE_MODE))
      begin
        next_compare_mode_select = reg_wdata[3:0];
      end
      else if (hit(`OFS_IRQ_ENABLE))
      begin
        next_irq_enable = reg_wdata;
      end
      else if (hit(`OFS_IRQ_STATUS))
      begin
        // Status is read-only
        next_irq_status = irq_status;
      end
      else if (hit(`OFS_IRQ_CLEAR))
      begin
        next_irq_status = irq_status & ~reg_wdata;
      end
    end
    // Flag sets regardless of enables
    if (pin_edge)
    begin
      next_irq_control[`BIT_PIN_FLAG] = 1'b1;
    end
    if (t0_ovf)
    begin
      next_irq_control[`BIT_TIMER0_FLAG] = 1'b1;
    end
    if (port_change)
    begin
      next_irq_control[`BIT_PORT_FLAG] = 1'b1;
    end
    next_periph_irq_flags = next_periph_irq_flags | (src_events & `PERIPH_MASK);
    // Sticky status behind the level output
    next_irq_status = next_irq_status | {5'h00, t1_ovf, port_change | pin_edge, t0_ovf};
    if (return_from_irq_instr)
    begin
      next_irq_control[`BIT_GLOBAL_EN] = 1'b1;
    end
    // Global enable drops as the vector is taken
    if (seq == irq_logic_pkg::vector_st)
    begin
      next_irq_control[`BIT_GLOBAL_EN] = 1'b0;
    end
  end

  // Acceptance sequencer
  always_comb
  begin
    next_seq = seq;
    next_hold_cnt = hold_cnt;
    next_push_addr = push_addr;
    next_push_stack = 1'b0;
    next_vector_take = 1'b0;
    case (seq)
      irq_logic_pkg::run_st:
      begin
        if (request && cycle_en && !core_sleeping)
        begin
          next_seq = irq_logic_pkg::hold_st;
          next_hold_cnt = `LATENCY_HOLD;
        end
      end
      irq_logic_pkg::hold_st:
      begin
        if (cycle_en)
        begin
          next_hold_cnt = hold_cnt - 2'h1;
          if (hold_cnt == 2'h1)
          begin
            next_seq = irq_logic_pkg::vector_st;
          end
        end
      end
      irq_logic_pkg::vector_st:
      begin
        next_push_addr = return_pc;
        next_push_stack = 1'b1;
        next_vector_take = 1'b1;
        next_seq = irq_logic_pkg::run_st;
      end
      default:
      begin
        next_seq = irq_logic_pkg::run_st;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      seq <= irq_logic_pkg::run_st;
      hold_cnt <= 2'h0;
      push_addr <= 13'h0000;
      push_stack <= 1'b0;
      irq_vector_take <= 1'b0;
    end
    else
    begin
      seq <= next_seq;
      hold_cnt <= next_hold_cnt;
      push_addr <= next_push_addr;
      push_stack <= next_push_stack;
      irq_vector_take <= next_vector_take;
    end
  end

  // Read port, data one cycle after the strobe
  always_comb
  begin
    next_reg_rdata = 8'h00;
    if (reg_rd)
    begin
      if (hit(`OFS_IRQ_CONTROL))
      begin
        next_reg_rdata = irq_control;
      end
      else if (hit(`OFS_PERIPH_IRQ_FLAGS))
      begin
        next_reg_rdata = periph_irq_flags;
      end
      else if (hit(`OFS_PERIPH_IRQ_ENABLES))
      begin
        next_reg_rdata = periph_irq_enables;
      end
      else if (hit(`OFS_TIMER1_COUNT_LOW))
      begin
        next_reg_rdata = timer1_count[7:0];
      end
      else if (hit(`OFS_TIMER1_COUNT_HIGH))
      begin
        next_reg_rdata = timer1_count[15:8];
      end
      else if (hit(`OFS_TIMER1_CONTROL))
      begin
        next_reg_rdata = timer1_control;
      end
      else if (hit(`OFS_TIMER0_COUNT))
      begin
        next_reg_rdata = timer0_count;
      end
      else if (hit(`OFS_OPTION))
      begin
        next_reg_rdata = option_reg;
      end
      else if (hit(`OFS_COMPARE_MODE))
      begin
        next_reg_rdata = {4'h0, compare_mode_select};
      end
      else if (hit(`OFS_IRQ_STATUS))
      begin
        next_reg_rdata = irq_status;
      end
      else if (hit(`OFS_IRQ_ENABLE))
      begin
        next_reg_rdata = irq_enable;
      end
      else
      begin
        next_reg_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
    end
    else
    begin
      reg_rdata <= next_reg_rdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_control <= `RESET_IRQ_CONTROL;
      periph_irq_flags <= `RESET_BYTE;
      periph_irq_enables <= `RESET_BYTE;
      timer1_control <= `RESET_BYTE;
      timer1_count <= 16'h0000;
      timer0_count <= `RESET_BYTE;
      option_reg <= `RESET_OPTION;
      compare_mode_select <= 4'h0;
      irq_enable <= `RESET_BYTE;
      irq_status <= `RESET_BYTE;
      pin_q <= 1'b0;
      port_q <= 4'h0;
      adc_start <= 1'b0;
    end
    else
    begin
      irq_control <= next_irq_control;
      periph_irq_flags <= next_periph_irq_flags;
      periph_irq_enables <= next_periph_irq_enables;
      timer1_control <= next_timer1_control;
      timer1_count <= next_timer1_count;
      timer0_count <= next_timer0_count;
      option_reg <= next_option_reg;
      compare_mode_select <= next_compare_mode_select;
      irq_enable <= next_irq_enable;
      irq_status <= next_irq_status;
      pin_q <= next_pin_q;
      port_q <= next_port_q;
      adc_start <= next_adc_start;
    end
  end

  assign vector_pc = `IRQ_VECTOR;
  assign wake = core_sleeping && pend_any;
  assign irq = |(irq_status & irq_enable);
endmodule // mcu_interrupt_logic

/* verif/mcu_interrupt_logic_asserts.sv */
`timescale 1ns/1ps
module mcu_interrupt_logic_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Watched ports
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic compare_match,
  input wire logic core_sleeping,
  input wire logic irq_vector_take,
  input wire logic [12:0] vector_pc,
  input wire logic push_stack,
  input wire logic wake,
  input wire logic adc_start
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // No second take in the eight cycles after a take
  sequence no_take_8;
    !irq_vector_take [*8];
  endsequence
  a_vector_fixed: assert property (vector_pc == 13'h0004) else $error("bad vector");
  a_push_with_take: assert property (push_stack == irq_vector_take)
    else $error("push unpaired");
  a_take_single: assert property (irq_vector_take |=> no_take_8) else $error("take again");
  a_reset_quiet: assert property ($fell(rst) |-> !irq_vector_take && !adc_start)
    else $error("active after reset");
  a_wake_sleep: assert property (wake |-> core_sleeping) else $error("wake while awake");
  a_adc_cause: assert property (adc_start |-> $past(compare_match))
    else $error("adc start uncaused");
  a_adc_single: assert property (adc_start |=> !adc_start) else $error("adc start long");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("rdata not idle");
endmodule // mcu_interrupt_logic_asserts
bind mcu_interrupt_logic mcu_interrupt_logic_asserts mcu_interrupt_logic_asserts_i (
  .mclk(mclk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .compare_match(compare_match), .core_sleeping(core_sleeping),
  .irq_vector_take(irq_vector_take), .vector_pc(vector_pc), .push_stack(push_stack),
  .wake(wake), .adc_start(adc_start));

/* verif/irq_core_model.sv */
`timescale 1ns/1ps
module irq_core_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Block handshake
  input wire logic irq_vector_take,
  input wire logic [12:0] vector_pc,
  input wire logic push_stack,
  output logic cycle_en,
  output logic [12:0] return_pc,
  output logic return_from_irq_instr,
  // Bench command
  input wire logic do_return
);
  logic [1:0] phase;
  logic [12:0] stack;
  // Pc held still so the pushed address is known
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      phase <= 2'h0;
      cycle_en <= 1'b0;
      return_pc <= 13'h0123;
      return_from_irq_instr <= 1'b0;
    end
    else
    begin
      phase <= phase + 2'h1;
      cycle_en <= (phase == 2'h3);
      return_from_irq_instr <= do_return;
      if (push_stack)
        stack <= return_pc;
      if (irq_vector_take)
        return_pc <= vector_pc;
      else if (do_return)
        return_pc <= stack;
    end
  end
endmodule // irq_core_model

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, ext_irq_pin = 1'b0, compare_match = 1'b0;
  logic core_sleeping = 1'b0, do_return = 1'b0;
  logic [3:0] port_b_a = 4'h0;
  logic [7:0] periph_events = 8'h00;
  logic [7:0] reg_rdata, v;
  logic cycle_en, return_from_irq_instr, irq_vector_take, push_stack, wake, adc_start, irq;
  logic [12:0] return_pc, vector_pc, push_addr;
  logic [7:0] rst_addr [5] = '{8'h0b, 8'h0c, 8'h8c, 8'h10, 8'h55};
  int bad_count = 0, n_checks = 0, cyc = 0, takes = 0, t0, n;
  always #5 mclk = ~mclk;
  mcu_interrupt_logic mcu_interrupt_logic_i (.mclk(mclk), .rst(rst), .cycle_en(cycle_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_irq_pin(ext_irq_pin), .port_b_a(port_b_a),
    .periph_events(periph_events), .compare_match(compare_match), .core_sleeping(core_sleeping),
    .return_from_irq_instr(return_from_irq_instr), .return_pc(return_pc),
    .irq_vector_take(irq_vector_take), .vector_pc(vector_pc), .push_addr(push_addr),
    .push_stack(push_stack), .wake(wake), .adc_start(adc_start), .irq(irq));
  irq_core_model irq_core_model_i (.mclk(mclk), .rst(rst), .irq_vector_take(irq_vector_take),
    .vector_pc(vector_pc), .push_stack(push_stack), .cycle_en(cycle_en),
    .return_pc(return_pc), .return_from_irq_instr(return_from_irq_instr),
    .do_return(do_return));
  always @(posedge mclk)
  begin
    cyc++;
    if (irq_vector_take === 1'b1)
      takes++;
    if (cyc == 20000)
    begin
      bad_count++;
      finish_test;
    end
  end
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [12:0] got, input logic [12:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task ex(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    chk(13'(v & m), 13'(e));
  endtask
  task pins(input logic p, input logic [3:0] b, input int k);
    @(posedge mclk);
    ext_irq_pin <= p;
    port_b_a <= b;
    repeat (k) @(posedge mclk);
  endtask
  task cmp_pulse;
    @(posedge mclk);
    compare_match <= 1'b1;
    @(posedge mclk);
    compare_match <= 1'b0;
    #1;
  endtask
  task t_reset;
    foreach (rst_addr[i])
      ex(rst_addr[i], 8'hff, 8'h00);
  endtask
  task t_flags;
    pins(1'b1, 4'h0, 2);
    ex(8'h0b, 8'h02, 8'h02);
    wr(8'h81, 8'hbf);
    wr(8'h0b, 8'h00);
    pins(1'b0, 4'h8, 2);
    ex(8'h0b, 8'h03, 8'h03);
    chk(13'(takes), 13'h0000);
  endtask
  task t_vector;
    wr(8'h81, 8'hff);
    wr(8'h0b, 8'h90);
    t0 = takes;
    n = 0;
    pins(1'b1, 4'h8, 0);
    repeat (60)
    begin
      @(posedge mclk);
      #1;
      if (irq_vector_take === 1'b1)
        break;
      if (cycle_en === 1'b1)
        n++;
    end
    chk(13'(irq_vector_take), 13'h0001);
    chk(13'(n >= 3 && n <= 4), 13'h0001);
    chk(push_addr, 13'h0123);
    ex(8'h0b, 8'h82, 8'h02);
    wr(8'h0b, 8'h10);
    @(posedge mclk);
    do_return <= 1'b1;
    @(posedge mclk);
    do_return <= 1'b0;
    ex(8'h0b, 8'hff, 8'h90);
    repeat (40) @(posedge mclk);
    chk(13'(takes), 13'(t0 + 1));
  endtask
  task t_wake;
    wr(8'h0b, 8'h10);
    @(posedge mclk);
    core_sleeping <= 1'b1;
    pins(1'b0, 4'h8, 2);
    #1 chk(13'(wake), 13'h0000);
    pins(1'b1, 4'h8, 2);
    #1 chk(13'(wake), 13'h0001);
    repeat (30) @(posedge mclk);
    core_sleeping <= 1'b0;
    chk(13'(takes), 13'(t0 + 1));
  endtask
  task t_timer0;
    wr(8'h0b, 8'h00);
    wr(8'h92, 8'hff);
    wr(8'h01, 8'hfe);
    repeat (12) @(posedge mclk);
    ex(8'h0b, 8'h04, 8'h04);
    ex(8'h90, 8'h01, 8'h01);
    chk(13'(irq), 13'h0000);
    wr(8'h91, 8'h01);
    #1 chk(13'(irq), 13'h0001);
    wr(8'h92, 8'h01);
    #1 chk(13'(irq), 13'h0000);
  endtask
  task t_timer1;
    wr(8'h8c, 8'h01);
    wr(8'h0f, 8'hff);
    wr(8'h0e, 8'hfe);
    wr(8'h10, 8'h01);
    wr(8'h0b, 8'h80);
    repeat (16) @(posedge mclk);
    ex(8'h0c, 8'h01, 8'h01);
    chk(13'(takes), 13'(t0 + 1));
    wr(8'h0b, 8'hc0);
    repeat (30) @(posedge mclk);
    chk(13'(takes), 13'(t0 + 2));
    wr(8'h10, 8'h00);
    wr(8'h0c, 8'h00);
    wr(8'h0f, 8'hff);
    wr(8'h0e, 8'hff);
    cmp_pulse;
    chk(13'(adc_start), 13'h0000);
    ex(8'h0f, 8'hff, 8'hff);
    wr(8'h17, 8'h0b);
    cmp_pulse;
    chk(13'(adc_start), 13'h0001);
    ex(8'h0e, 8'hff, 8'h00);
    ex(8'h0f, 8'hff, 8'h00);
    ex(8'h0c, 8'h01, 8'h00);
    @(posedge mclk);
    periph_events <= 8'hff;
    @(posedge mclk);
    periph_events <= 8'h00;
    ex(8'h0c, 8'hff, 8'h4e);
    wr(8'h0f, 8'h5a);
    @(posedge mclk);
    compare_match <= 1'b1;
    reg_addr <= 8'h0e;
    reg_wdata <= 8'h37;
    reg_wr <= 1'b1;
    @(posedge mclk);
    compare_match <= 1'b0;
    reg_wr <= 1'b0;
    ex(8'h0e, 8'hff, 8'h37);
    ex(8'h0f, 8'hff, 8'h5a);
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_flags;
    t_vector;
    t_wake;
    t_timer0;
    t_timer1;
    finish_test;
  end
endmodule // tb
